// ===== design/dmc_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_regs (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ctrlSelectN,
  input  wire logic              ctrlClk,
  input  wire logic              ctrlData,
  input  wire logic              zeroDetectL,
  input  wire logic              zeroDetectR,
  output dmc_pkg::dmc_cfg_s      cfg,
  output dmc_pkg::dmc_dec_s      dec,
  output logic                   leftZeroFlag,
  output logic                   leftZeroFlagOe,
  output logic                   rightZeroFlag
);
  import dmc_pkg::*;

  // Two-stage synchronisers; stage one feeds stage two only
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic [2:0] syncC_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncA_q <= 3'h7;
      syncB_q <= 3'h7;
      syncC_q <= 3'h7;
    end else begin
      syncA_q <= {ctrlSelectN, ctrlClk, ctrlData};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  wire selN      = syncB_q[2];
  wire selRise   = syncB_q[2] & ~syncC_q[2];
  wire clkRise   = syncB_q[1] & ~syncC_q[1];
  wire dataBit   = syncB_q[0];

  dmc_state_e state_q;
  dmc_state_e state_d;
  logic [WORD_BITS-1:0] shift_q;
  logic [CNT_BITS-1:0]  count_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (!selN) state_d = ST_SHIFT;
      ST_SHIFT: if (selRise) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // Longer frames are discarded rather than truncated, so a stray clock never writes
  wire countSat  = count_q > CNT_FULL;
  wire doShift   = (state_q == ST_SHIFT) && !selN && clkRise;
  wire wordDone  = (state_q == ST_SHIFT) && selRise && (count_q == CNT_FULL);
  wire wrEn      = wordDone && !shift_q[ZERO_BIT];
  wire [6:0] wrIdx  = shift_q[IDX_HI:IDX_LO];
  wire [7:0] wrData = shift_q[7:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        count_q <= '0;
      end else if (doShift) begin
        shift_q <= {shift_q[WORD_BITS-2:0], dataBit};
        if (!countSat) count_q <= count_q + 5'h1;
      end
    end
  end

  // Reserved bits are not stored; the host keeps them zero
  wire wrDeemph = wrEn && (wrIdx == IDX_DEEMPH);
  wire wrFormat = wrEn && (wrIdx == IDX_FORMAT);
  wire wrAtten  = wrEn && (wrIdx == IDX_ATTEN);
  wire wrZflag  = wrEn && (wrIdx == IDX_ZFLAG);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg <= '0;
      cfg.audioFormatSelect <= FMT_RESET;
    end else begin
      if (wrDeemph) begin
        cfg.deemphEnable     <= wrData[DM_EN_BIT];
        cfg.deemphRateSelect <= wrData[DM_RATE_LO+1:DM_RATE_LO];
      end
      if (wrFormat) begin
        cfg.audioFormatSelect <= wrData[FMT_LO+2:FMT_LO];
        cfg.rolloffSelect     <= wrData[FLT_BIT];
      end
      if (wrAtten) cfg.attenuationStepMode <= wrData[ATTENUATION_STEP_MODE_BIT];
      if (wrZflag) begin
        cfg.outputPhaseInvert   <= wrData[OUTPUT_PHASE_INVERT_BIT];
        cfg.zeroFlagPolarity    <= wrData[ZERO_FLAG_POLARITY_BIT];
        cfg.zeroFlagPinFunction <= wrData[ZERO_FLAG_PIN_FUNCTION_BIT];
      end
    end
  end

  // Decoded view lags the register by one cycle
  dmc_dec_s decNext;
  wire fmtRj = (cfg.audioFormatSelect <= FMT_RJ16);
  always_comb begin
    decNext = '0;
    decNext.rightJustified = fmtRj;
    decNext.i2sFormat      = cfg.audioFormatSelect == FMT_I2S;
    decNext.leftJustified  = cfg.audioFormatSelect == FMT_LJ;
    decNext.formatReserved = cfg.audioFormatSelect > FMT_LJ;
    case (cfg.audioFormatSelect)
      FMT_RJ20: decNext.wordBits = BITS_20;
      FMT_RJ18: decNext.wordBits = BITS_18;
      FMT_RJ16: decNext.wordBits = BITS_16;
      default:  decNext.wordBits = BITS_24;
    endcase
    decNext.stepHalfDb = cfg.attenuationStepMode ? STEP_WIDE : STEP_FINE;
    decNext.floorDb    = cfg.attenuationStepMode ? FLOOR_WIDE : FLOOR_FINE;
    decNext.deemphActive = cfg.deemphEnable;
    decNext.deemphRate   = cfg.deemphEnable ? cfg.deemphRateSelect : RATE_44K1;
    decNext.deemphRateReserved = cfg.deemphEnable && (cfg.deemphRateSelect > RATE_32K);
  end

  wire bothZero   = zeroDetectL & zeroDetectR;
  wire rightLevel = cfg.zeroFlagPinFunction ? bothZero : zeroDetectR;
  wire leftLevel  = zeroDetectL;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dec            <= '0;
      leftZeroFlag   <= 1'b0;
      leftZeroFlagOe <= 1'b1;
      rightZeroFlag  <= 1'b0;
    end else begin
      dec            <= decNext;
      leftZeroFlag   <= cfg.zeroFlagPinFunction ? 1'b0 : leftLevel ^ cfg.zeroFlagPolarity;
      leftZeroFlagOe <= !cfg.zeroFlagPinFunction;
      rightZeroFlag  <= rightLevel ^ cfg.zeroFlagPolarity;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fmt_reset_value: assert property ($rose(rst_n) |-> cfg.audioFormatSelect == FMT_RESET)
    else $error("format field not at reset code");
  a_fmt_write_takes: assert property (
    wrFormat |=> cfg.audioFormatSelect == $past(wrData[FMT_LO+2:FMT_LO]))
    else $error("format write not stored");
  a_other_idx_keep: assert property (
    wrEn && wrIdx != IDX_FORMAT |=> $stable(cfg.audioFormatSelect) && $stable(cfg.rolloffSelect))
    else $error("foreign write changed format register");
  a_word_bit15_block: assert property (wordDone && shift_q[ZERO_BIT] |=> $stable(cfg))
    else $error("word with bit 15 set was written");
  a_short_frame_drop: assert property (
    state_q == ST_SHIFT && selRise && count_q != CNT_FULL |=> $stable(cfg))
    else $error("frame of wrong length was written");
  a_idx_unimpl_drop: assert property (
    wrEn && (wrIdx < IDX_DEEMPH || wrIdx > IDX_ZFLAG) |=> $stable(cfg))
    else $error("unimplemented index write changed a register");
  a_rolloff_write: assert property (
    wrFormat |=> cfg.rolloffSelect == $past(wrData[FLT_BIT]))
    else $error("rolloff bit not stored");
  // Sampled reset term keeps the release edge, where dec is still cleared, out of decode checks
  a_rj_decode: assert property (
    rst_n && cfg.audioFormatSelect <= FMT_RJ16 |=> dec.rightJustified && !dec.leftJustified)
    else $error("right-justified decode wrong");
  a_rj_word_width: assert property (
    rst_n && cfg.audioFormatSelect == FMT_RJ18 |=> dec.wordBits == BITS_18)
    else $error("right-justified word width wrong");
  a_i2s_decode: assert property (
    rst_n && cfg.audioFormatSelect == FMT_I2S |=> dec.i2sFormat && !dec.rightJustified)
    else $error("I2S format decode wrong");
  a_fmt_reserved: assert property (
    rst_n && cfg.audioFormatSelect > FMT_LJ |=> dec.formatReserved && !dec.leftJustified)
    else $error("reserved format codes not flagged");
  a_lj_decode: assert property (
    rst_n && cfg.audioFormatSelect == FMT_LJ |=> dec.leftJustified && dec.wordBits == BITS_24)
    else $error("left-justified decode wrong");
  a_step_fine_mode: assert property (
    rst_n && !cfg.attenuationStepMode
    |=> dec.stepHalfDb == STEP_FINE && dec.floorDb == FLOOR_FINE)
    else $error("fine attenuation decode wrong");
  a_step_wide_mode: assert property (
    cfg.attenuationStepMode ##1 cfg.attenuationStepMode
    |-> dec.stepHalfDb == STEP_WIDE && dec.floorDb == FLOOR_WIDE)
    else $error("wide attenuation decode wrong");
  a_atten_write: assert property (
    wrAtten |=> cfg.attenuationStepMode == $past(wrData[ATTENUATION_STEP_MODE_BIT]))
    else $error("attenuation mode bit not stored");
  a_phase_write: assert property (
    wrZflag |=> cfg.outputPhaseInvert == $past(wrData[OUTPUT_PHASE_INVERT_BIT]))
    else $error("phase bit not stored");
  a_polarity_write: assert property (
    wrZflag |=> cfg.zeroFlagPolarity == $past(wrData[ZERO_FLAG_POLARITY_BIT]))
    else $error("flag polarity bit not stored");
  a_pinfunc_write: assert property (
    wrZflag |=> cfg.zeroFlagPinFunction == $past(wrData[ZERO_FLAG_PIN_FUNCTION_BIT]))
    else $error("flag function bit not stored");
  a_flag_pol_high: assert property (
    !cfg.zeroFlagPolarity && zeroDetectR && !cfg.zeroFlagPinFunction |=> rightZeroFlag)
    else $error("right flag not high on zero");
  a_flag_pol_low: assert property (
    cfg.zeroFlagPolarity && !cfg.zeroFlagPinFunction |=> rightZeroFlag == !$past(zeroDetectR))
    else $error("inverted flag polarity wrong");
  a_left_separate: assert property (
    !cfg.zeroFlagPinFunction |=> leftZeroFlagOe
    && leftZeroFlag == ($past(zeroDetectL) ^ $past(cfg.zeroFlagPolarity)))
    else $error("left flag not separate");
  a_right_separate: assert property (
    rst_n && !cfg.zeroFlagPinFunction
    |=> rightZeroFlag == ($past(zeroDetectR) ^ $past(cfg.zeroFlagPolarity)))
    else $error("right flag not separate");
  a_common_flag: assert property (
    cfg.zeroFlagPinFunction |=> !leftZeroFlagOe
    && rightZeroFlag == ($past(bothZero) ^ $past(cfg.zeroFlagPolarity)))
    else $error("common flag wrong");
  a_deemph_write: assert property (
    wrDeemph |=> cfg.deemphEnable == $past(wrData[DM_EN_BIT])
    && cfg.deemphRateSelect == $past(wrData[DM_RATE_LO+1:DM_RATE_LO]))
    else $error("de-emphasis fields not stored");
  a_deemph_gate: assert property (
    !cfg.deemphEnable |=> !dec.deemphActive && dec.deemphRate == RATE_44K1)
    else $error("rate active while de-emphasis off");
  a_rate_reserved: assert property (
    rst_n && cfg.deemphEnable && cfg.deemphRateSelect > RATE_32K |=> dec.deemphRateReserved)
    else $error("reserved de-emphasis rate not flagged");
  a_deemph_rate: assert property (
    cfg.deemphEnable |=> dec.deemphRate == $past(cfg.deemphRateSelect))
    else $error("de-emphasis rate decode wrong");

endmodule
`default_nettype wire

// ===== design/dmc_pkg.sv
// Contract
// - Format codes: right-justified 24/20/18/16, I2S, left-justified, reserved
// - Format field resets to left-justified code
// - Rolloff bit: zero sharp, one slow
// - Mode zero: half-dB steps down to -63
// - Mode one: one-dB steps down to -100
// - Phase bit one inverts both channel outputs
// - Polarity zero: flag high on zero data
// - Polarity one: flag low on zero data
// - Function zero: separate left and right flags
// - Function one: left unassigned, right common flag
// - De-emphasis rate applies only while enabled
// - Rate codes: 44.1, 48, 32 kHz
// - Word: zero, seven-bit index, eight data bits
package dmc_pkg;

  localparam int WORD_BITS = 16;
  localparam int CNT_BITS  = 5;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
  localparam int ZERO_BIT  = 15;
  localparam int IDX_HI    = 14;
  localparam int IDX_LO    = 8;

  localparam logic [6:0] IDX_DEEMPH = 7'h13;
  localparam logic [6:0] IDX_FORMAT = 7'h14;
  localparam logic [6:0] IDX_ATTEN  = 7'h15;
  localparam logic [6:0] IDX_ZFLAG  = 7'h16;

  localparam int DM_EN_BIT   = 4;
  localparam int DM_RATE_LO  = 5;
  localparam int FMT_LO      = 0;
  localparam int FLT_BIT     = 5;
  localparam int ATTENUATION_STEP_MODE_BIT    = 0;
  localparam int OUTPUT_PHASE_INVERT_BIT    = 0;
  localparam int ZERO_FLAG_POLARITY_BIT    = 1;
  localparam int ZERO_FLAG_PIN_FUNCTION_BIT    = 2;

  localparam logic [2:0] FMT_RJ24  = 3'h0;
  localparam logic [2:0] FMT_RJ20  = 3'h1;
  localparam logic [2:0] FMT_RJ18  = 3'h2;
  localparam logic [2:0] FMT_RJ16  = 3'h3;
  localparam logic [2:0] FMT_I2S   = 3'h4;
  localparam logic [2:0] FMT_LJ    = 3'h5;
  localparam logic [2:0] FMT_RESET = FMT_LJ;

  localparam logic [4:0] BITS_24 = 5'h18;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_16 = 5'h10;

  localparam logic [1:0] STEP_FINE = 2'h1;
  localparam logic [1:0] STEP_WIDE = 2'h2;
  localparam logic [6:0] FLOOR_FINE = 7'h3f;
  localparam logic [6:0] FLOOR_WIDE = 7'h64;

  localparam logic [1:0] RATE_44K1 = 2'h0;
  localparam logic [1:0] RATE_48K  = 2'h1;
  localparam logic [1:0] RATE_32K  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } dmc_state_e;

  typedef struct packed {
    logic [2:0] audioFormatSelect;
    logic       rolloffSelect;
    logic       attenuationStepMode;
    logic       outputPhaseInvert;
    logic       zeroFlagPolarity;
    logic       zeroFlagPinFunction;
    logic       deemphEnable;
    logic [1:0] deemphRateSelect;
  } dmc_cfg_s;

  typedef struct packed {
    logic       rightJustified;
    logic       i2sFormat;
    logic       leftJustified;
    logic       formatReserved;
    logic [4:0] wordBits;
    logic [1:0] stepHalfDb;
    logic [6:0] floorDb;
    logic       deemphActive;
    logic [1:0] deemphRate;
    logic       deemphRateReserved;
  } dmc_dec_s;

endpackage

// ===== dv/dmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model (
  input  wire logic sys_clk,
  output var logic  ctrlSelectN,
  output var logic  ctrlClk,
  output var logic  ctrlData
);
  initial begin
    ctrlSelectN = 1'b1;
    ctrlClk = 1'b0;
    ctrlData = 1'b0;
  end

  // Each level lasts at least 4 cycles, since the device needs 3 to see it through its synchroniser
  task automatic send(input logic [15:0] word, input int nBits);
    @(posedge sys_clk);
    ctrlSelectN <= 1'b0;
    for (int i = 15; i > 15 - nBits; i--) begin
      @(posedge sys_clk);
      // Bits past the end of the word go out as zero, for over-long frames
      ctrlData <= (i >= 0) ? word[i] : 1'b0;
      repeat (4) @(posedge sys_clk);
      ctrlClk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ctrlClk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    ctrlSelectN <= 1'b1;
    // Stale data would hide a device that samples outside the frame
    ctrlData <= ~ctrlData;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/dmc_mode_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_regs_bench;
  import dmc_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       zeroDetectL = 1'b0;
  logic       zeroDetectR = 1'b0;
  wire logic  ctrlSelectN;
  wire logic  ctrlClk;
  wire logic  ctrlData;
  dmc_cfg_s   cfg;
  dmc_dec_s   dec;
  logic       leftZeroFlag;
  logic       leftZeroFlagOe;
  logic       rightZeroFlag;
  int         errors = 0;
  int         n_tests = 0;
  logic [4:0] bitsTab [0:3] = '{5'h18, 5'h14, 5'h12, 5'h10};
  logic [3:0] flagSeen;
  logic [3:0] flagExp;

  always #12.5 sys_clk = ~sys_clk;

  dmc_host_model dmc_host_model_inst (.sys_clk(sys_clk), .ctrlSelectN(ctrlSelectN),
    .ctrlClk(ctrlClk), .ctrlData(ctrlData));

  dmc_mode_regs dmc_mode_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .ctrlSelectN(ctrlSelectN), .ctrlClk(ctrlClk), .ctrlData(ctrlData),
    .zeroDetectL(zeroDetectL), .zeroDetectR(zeroDetectR), .cfg(cfg), .dec(dec),
    .leftZeroFlag(leftZeroFlag), .leftZeroFlagOe(leftZeroFlagOe),
    .rightZeroFlag(rightZeroFlag));

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ends on a falling edge so registered outputs have settled before compares
  task automatic wr(input logic [6:0] idx, input logic [7:0] data, input int nBits = 16,
                    input logic top = 1'b0);
    dmc_host_model_inst.send({top, idx, data}, nBits);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check(16'(cfg), 16'h0500);
    check(16'({dec.leftJustified, dec.wordBits, dec.stepHalfDb, dec.floorDb}), 16'h70bf);
    for (int f = 0; f < 8; f++) begin
      wr(IDX_FORMAT, {2'h0, f[0], 2'h0, f[2:0]});
      check(16'({cfg.audioFormatSelect, cfg.rolloffSelect}), 16'({f[2:0], f[0]}));
      check(16'({dec.rightJustified, dec.i2sFormat, dec.leftJustified, dec.formatReserved}),
            16'({f < 4, f == 4, f == 5, f > 5}));
      if (f < 4) check(16'(dec.wordBits), 16'(bitsTab[f]));
    end
    for (int m = 1; m >= 0; m--) begin
      wr(IDX_ATTEN, {7'h0, m[0]});
      check(16'({cfg.attenuationStepMode, dec.stepHalfDb, dec.floorDb}),
            m ? 16'h0364 : 16'h00bf);
    end
    for (int k = 0; k < 16; k++) begin
      if (k[1:0] == 2'h0) wr(IDX_ZFLAG, {5'h0, k[3], k[2], k[3]});
      @(posedge sys_clk);
      zeroDetectL <= k[1];
      zeroDetectR <= k[0];
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      flagSeen = {cfg.outputPhaseInvert, leftZeroFlagOe, leftZeroFlag, rightZeroFlag};
      flagExp = {k[3], !k[3], !k[3] && (k[1] ^ k[2]), (k[3] ? k[1] & k[0] : k[0]) ^ k[2]};
      check(16'(flagSeen), 16'(flagExp));
    end
    for (int d = 0; d < 8; d++) begin
      wr(IDX_DEEMPH, {1'b0, d[1:0], d[2], 4'h0});
      check(16'({cfg.deemphEnable, cfg.deemphRateSelect, dec.deemphActive}),
            16'({d[2], d[1:0], d[2]}));
      if (d[1:0] != 2'h3) check(16'(dec.deemphRate), d[2] ? 16'(d[1:0]) : 16'h0);
      check(16'(dec.deemphRateReserved), 16'(d == 7));
    end
    wr(IDX_FORMAT, 8'h03);
    // Refused frames: bit 15 set, short, long, unimplemented index
    wr(IDX_FORMAT, 8'h01, 16, 1'b1);
    wr(IDX_FORMAT, 8'h02, 15);
    // Its last 16 bits alone would write 8'h1a to the format register
    wr(7'h0a, 8'h0d, 17);
    wr(7'h17, 8'h07);
    wr(IDX_ATTEN, 8'h00);
    check(16'(cfg), 16'h033f);
    report_and_stop();
  end

  // Whole sequence needs about 4500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
